// ===== design/ksm_sense.sv
`timescale 1ns/100ps
`include "ksm_cfg.svh"

module ksm_sense
    import ksm_pkg::*;
#(
    parameter int N_SENSE = 8,
    parameter int N_SCAN = 18
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [N_SENSE-1:0] key_sense_inputs,
    input wire logic bus_clk_stopped,
    input wire logic scan_select_change,
    input wire logic [N_SCAN-1:0] scan_level_req,
    output logic [N_SCAN-1:0] scan_drive_lines_o,
    output logic [N_SCAN-1:0] scan_drive_lines_oe,
    output logic matrix_runtime_irq,
    output logic matrix_wake_irq,
    output logic clock_request
);

    // ---------------------------------------------------------------
    // Parameter checks
    // ---------------------------------------------------------------
    if (N_SENSE < 1 || N_SENSE > 8) begin : g_bad_sense
        $error("N_SENSE must lie between 1 and 8.");
    end
    if (N_SCAN < 1 || N_SCAN > 32) begin : g_bad_scan
        $error("N_SCAN must lie between 1 and 32.");
    end

    localparam int PD_W = 8;
    localparam logic [PD_W-1:0] PD_LOAD = PD_W'(`KSM_PREDRIVE_CYCLES);
    localparam logic [PD_W-1:0] PD_ONE = PD_W'(1);

    function automatic logic [31:0] ksm_zext(input logic [N_SENSE-1:0] v);
        logic [31:0] r;
        r = '0;
        r[N_SENSE-1:0] = v;
        return r;
    endfunction

    function automatic logic ksm_hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // ---------------------------------------------------------------
    // Sense synchroniser and edge detect
    // ---------------------------------------------------------------
    logic [N_SENSE-1:0] sense_meta;
    logic [N_SENSE-1:0] sense_level;
    logic [N_SENSE-1:0] sense_prev;
    logic [N_SENSE-1:0] sense_fall;

    // The first stage is read only by the second; edges use stage two.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_meta <= '0;
            sense_level <= '0;
            sense_prev <= '0;
        end else begin
            sense_meta <= key_sense_inputs;
            sense_level <= sense_meta;
            sense_prev <= sense_level;
        end
    end

    // Resetting the chain low means lines idling high after reset give no false edge.
    assign sense_fall = sense_prev & ~sense_level;

    // ---------------------------------------------------------------
    // APB slave
    // ---------------------------------------------------------------
    logic setup_phase;
    logic access_wr;
    logic hit_levels;
    logic hit_flags;
    logic hit_enables;
    logic hit_extctl;
    logic hit_any;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [N_SENSE-1:0] sense_fall_flags;
    logic [N_SENSE-1:0] sense_irq_mask;
    logic predrive_en;

    assign setup_phase = psel & ~penable;
    assign access_wr = psel & penable & pwrite & pready & ~pslverr;
    assign hit_levels = ksm_hit(paddr, `KSM_OFS_LEVELS);
    assign hit_flags = ksm_hit(paddr, `KSM_OFS_FLAGS);
    assign hit_enables = ksm_hit(paddr, `KSM_OFS_ENABLES);
    assign hit_extctl = ksm_hit(paddr, `KSM_OFS_EXTCTL);
    assign hit_any = hit_levels | hit_flags | hit_enables | hit_extctl;
    // Read data is captured in the setup cycle so that it comes from a flop
    // while the access phase still completes without wait states.
    // Writes to the level register and to unmapped offsets are dropped.
    assign pready = 1'b1;

    always_comb begin
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (setup_phase) begin
            next_pslverr = ~hit_any;
            next_prdata = '0;
            if (!pwrite) begin
                if (hit_levels) begin
                    next_prdata = ksm_zext(sense_level);
                end
                if (hit_flags) begin
                    next_prdata = ksm_zext(sense_fall_flags);
                end
                if (hit_enables) begin
                    next_prdata = ksm_zext(sense_irq_mask);
                end
                if (hit_extctl) begin
                    next_prdata[`KSM_PREDRIVE_BIT] = predrive_en;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // ---------------------------------------------------------------
    // Flags, enables and control
    // ---------------------------------------------------------------
    logic [N_SENSE-1:0] next_flags;
    logic [N_SENSE-1:0] next_mask;
    logic next_predrive_en;
    logic [N_SENSE-1:0] clear_bits;

    // Enables and control take effect at the access edge of a write.
    always_comb begin
        clear_bits = '0;
        next_mask = sense_irq_mask;
        next_predrive_en = predrive_en;
        if (access_wr && pstrb[0]) begin
            if (hit_flags) begin
                clear_bits = pwdata[N_SENSE-1:0];
            end
            if (hit_enables) begin
                next_mask = pwdata[N_SENSE-1:0];
            end
            if (hit_extctl) begin
                next_predrive_en = pwdata[`KSM_PREDRIVE_BIT];
            end
        end
        // A fresh edge beats a clear in the same cycle.
        next_flags = (sense_fall_flags & ~clear_bits) | sense_fall;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_fall_flags <= '0;
            sense_irq_mask <= '0;
            predrive_en <= 1'b0;
        end else begin
            sense_fall_flags <= next_flags;
            sense_irq_mask <= next_mask;
            predrive_en <= next_predrive_en;
        end
    end

    // ---------------------------------------------------------------
    // Interrupts
    // ---------------------------------------------------------------
    logic [N_SENSE-1:0] line_req;
    logic any_req;
    logic rearm;
    logic irq_blocked;
    logic irq_shown;
    logic wake_hold;
    logic next_irq_blocked;
    logic next_irq_shown;
    logic next_wake_hold;

    assign line_req = sense_fall_flags & sense_irq_mask;
    assign any_req = |line_req;
    assign rearm = (&sense_level) | scan_select_change;

    always_comb begin
        next_irq_blocked = irq_blocked;
        if (rearm) begin
            next_irq_blocked = 1'b0;
        end else if (irq_shown && !any_req) begin
            next_irq_blocked = 1'b1;
        end
        // The block is armed from the level shown last cycle, so it only
        // starts once the runtime interrupt has really been seen to drop.
        next_irq_shown = matrix_runtime_irq;
        next_wake_hold = wake_hold;
        if (!bus_clk_stopped) begin
            next_wake_hold = 1'b0;
        end else if (|(sense_fall & sense_irq_mask)) begin
            next_wake_hold = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_blocked <= 1'b0;
            irq_shown <= 1'b0;
            wake_hold <= 1'b0;
        end else begin
            irq_blocked <= next_irq_blocked;
            irq_shown <= next_irq_shown;
            wake_hold <= next_wake_hold;
        end
    end

    // Both interrupts are decoded from the same flops so that the runtime
    // interrupt can never stand while the wake interrupt is low; a clear
    // drops them together in the cycle of the write, unless wake_hold keeps the wake interrupt up.
    assign matrix_runtime_irq = any_req & ~irq_blocked & ~bus_clk_stopped;
    assign matrix_wake_irq = any_req | wake_hold;
    assign clock_request = wake_hold;

    // ---------------------------------------------------------------
    // Scan predrive
    // ---------------------------------------------------------------
    ksm_pd_state_e pd_state;
    ksm_pd_state_e next_pd_state;
    logic [PD_W-1:0] pd_count;
    logic [PD_W-1:0] next_pd_count;
    logic [N_SCAN-1:0] scan_level;
    logic [N_SCAN-1:0] pd_lines;
    logic [N_SCAN-1:0] next_pd_lines;
    logic [N_SCAN-1:0] released;

    // One shared counter serves all lines; a later release restarts it,
    // so an earlier line may be driven a little longer, never shorter.
    assign released = scan_level_req & ~scan_level;

    always_comb begin
        next_pd_state = pd_state;
        next_pd_count = pd_count;
        next_pd_lines = pd_lines;
        unique case (pd_state)
            KSM_PD_IDLE: begin
                next_pd_lines = '0;
                if (predrive_en && |released) begin
                    next_pd_state = KSM_PD_DRIVE;
                    next_pd_count = PD_LOAD;
                    next_pd_lines = released;
                end
            end
            KSM_PD_DRIVE: begin
                if (!predrive_en) begin
                    next_pd_state = KSM_PD_IDLE;
                    next_pd_lines = '0;
                end else if (|released) begin
                    next_pd_count = PD_LOAD;
                    next_pd_lines = (pd_lines | released) & scan_level_req;
                end else if (pd_count == PD_ONE) begin
                    next_pd_state = KSM_PD_IDLE;
                    next_pd_lines = '0;
                end else begin
                    next_pd_count = pd_count - PD_ONE;
                    next_pd_lines = pd_lines & scan_level_req;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_state <= KSM_PD_IDLE;
            pd_count <= '0;
            pd_lines <= '0;
            scan_level <= '1;
            scan_drive_lines_o <= '0;
            scan_drive_lines_oe <= '0;
        end else begin
            pd_state <= next_pd_state;
            pd_count <= next_pd_count;
            pd_lines <= next_pd_lines;
            scan_level <= scan_level_req;
            // Low lines sink; predriven lines source high; the rest float.
            scan_drive_lines_o <= next_pd_lines;
            scan_drive_lines_oe <= ~scan_level_req | next_pd_lines;
        end
    end

endmodule

// ===== pkg/ksm_cfg.svh
`ifndef KSM_CFG_SVH
`define KSM_CFG_SVH
// Function
// - The input register returns the live level of the eight sense lines, upper bits zero.
// - A falling edge on a sense line sets its flag, which stays until software clears it.
// - A line requests an interrupt only while its flag and its enable bit are both set.
// - All line requests are ORed onto the runtime interrupt and the wake interrupt.
// - Writing one to a flag bit clears it, writing zero leaves it unchanged.
// - Eight read-write enable bits gate whether each line's edges can interrupt.
// - With predrive on, released scan lines are driven high two 25 MHz pclk cycles, at least two 48 MHz cycles, then float.
// - Bit zero of the extended control register enables predrive, read-write, reset zero.
// - After the runtime interrupt drops with its requests cleared, it stays off until all lines are high or the scan select changes.
// - With the bus clock stopped, an enabled edge raises wake and a clock request until the clock runs.

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define KSM_OFS_LEVELS 8'h08
`define KSM_OFS_FLAGS 8'h0C
`define KSM_OFS_ENABLES 8'h10
`define KSM_OFS_EXTCTL 8'h14
`define KSM_PREDRIVE_BIT 0
`define KSM_RESET_BYTE 8'h00

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define KSM_CLK_MHZ 25
`define KSM_PLL_MHZ 48
`define KSM_PREDRIVE_PLL_CYCLES 2
`define KSM_PREDRIVE_CYCLES \
    ((`KSM_PREDRIVE_PLL_CYCLES * `KSM_CLK_MHZ + `KSM_PLL_MHZ - 1) / `KSM_PLL_MHZ)
`endif

// ===== pkg/ksm_pkg.sv
package ksm_pkg;
    typedef enum logic [1:0] {
        KSM_PD_IDLE = 2'b01,
        KSM_PD_DRIVE = 2'b10
    } ksm_pd_state_e;

    typedef logic [7:0] ksm_byte_t;
endpackage

// ===== testbench/ksm_sense_asserts.sv
`timescale 1ns/100ps
module ksm_sense_asserts #(
    parameter int N_SENSE = 8,
    parameter int N_SCAN = 18
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [N_SENSE-1:0] key_sense_inputs,
    input wire logic bus_clk_stopped,
    input wire logic scan_select_change,
    input wire logic [N_SCAN-1:0] scan_level_req,
    input wire logic [N_SCAN-1:0] scan_drive_lines_o,
    input wire logic [N_SCAN-1:0] scan_drive_lines_oe,
    input wire logic matrix_runtime_irq,
    input wire logic matrix_wake_irq,
    input wire logic clock_request
);
    logic wr;
    logic pd;
    logic [7:0] en;
    logic blk;
    assign wr = psel && penable && pready && pwrite && pstrb[0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd <= 1'b0;
            en <= 8'h00;
            blk <= 1'b0;
        end else begin
            if (wr && paddr == 8'h14) pd <= pwdata[0];
            if (wr && paddr == 8'h10) en <= pwdata[7:0];
            // Raw lines lead the synchroniser, so this unblocks early, never late.
            if (&key_sense_inputs || scan_select_change) blk <= 1'b0;
            else if ($fell(matrix_runtime_irq)) blk <= 1'b1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    upper_zero_a: assert property (psel && penable |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    edge_wake_a: assert property ($fell(key_sense_inputs[0]) && en[0] |-> ##3 matrix_wake_irq)
        else $error("enabled fall gave no wake");
    wake_or_a: assert property (matrix_runtime_irq |-> matrix_wake_irq)
        else $error("runtime without wake");
    rearm_block_a: assert property (blk |-> !matrix_runtime_irq)
        else $error("runtime irq before rearm");
    pd_pulse_a: assert property ($rose(scan_level_req[0]) && pd |=>
        (scan_drive_lines_o[0] && scan_drive_lines_oe[0]) [*2] ##1 !scan_drive_lines_oe[0])
        else $error("predrive pulse wrong");
    pd_off_a: assert property ($rose(scan_level_req[0]) && !pd |=> !scan_drive_lines_oe[0])
        else $error("line driven with predrive off");
    wake_hold_a: assert property (clock_request |-> matrix_wake_irq)
        else $error("clock request without wake");
    clk_back_a: assert property ($fell(bus_clk_stopped) |=> !clock_request)
        else $error("clock request kept");
endmodule
bind ksm_sense ksm_sense_asserts #(.N_SENSE(N_SENSE), .N_SCAN(N_SCAN)) i_ksm_sense_asserts (.*);

// ===== testbench/ksm_keys.sv
`timescale 1ns/100ps
module ksm_keys (
    input wire logic [7:0] press,
    input wire logic scan_o,
    input wire logic scan_oe,
    output logic [7:0] sense
);
    // A key pulls its line low only while scan line 0 sinks; pull-ups win otherwise.
    assign sense = ~(press & {8{scan_oe && !scan_o}});
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, er, matrix_runtime_irq, matrix_wake_irq, clock_request;
    logic [7:0] key_sense_inputs, press = 8'h00;
    logic bus_clk_stopped = 1'b0, scan_select_change = 1'b0;
    logic [17:0] scan_level_req = 18'h3FFFE, scan_drive_lines_o, scan_drive_lines_oe;
    int errors = 0, checked = 0;
    always #20 pclk = ~pclk;
    ksm_sense i_ksm_sense (.*);
    ksm_keys i_ksm_keys (.press(press), .scan_o(scan_drive_lines_o[0]),
        .scan_oe(scan_drive_lines_oe[0]), .sense(key_sense_inputs));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            errors++;
            test_done();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
        check(er, e);
    endtask
    task t_reset;
        cyc(4);
        rd_chk(8'h08, 32'hFF, 1'b0);
        rd_chk(8'h0C, 32'h0, 1'b0);
        rd_chk(8'h10, 32'h0, 1'b0);
        rd_chk(8'h14, 32'h0, 1'b0);
        rd_chk(8'h00, 32'h0, 1'b1);
        apb(1'b1, 8'h08, 32'h0);
        rd_chk(8'h08, 32'hFF, 1'b0);
        $display("reset test done");
    endtask
    task t_edge;
        apb(1'b1, 8'h10, 32'h1);
        rd_chk(8'h10, 32'h1, 1'b0);
        @(posedge pclk) press <= 8'hFF;
        cyc(6);
        check(matrix_runtime_irq, 1'b1);
        check(matrix_wake_irq, 1'b1);
        rd_chk(8'h08, 32'h0, 1'b0);
        rd_chk(8'h0C, 32'hFF, 1'b0);
        apb(1'b1, 8'h0C, 32'h0F);
        rd_chk(8'h0C, 32'hF0, 1'b0);
        cyc(2);
        check(matrix_runtime_irq, 1'b0);
        apb(1'b1, 8'h10, 32'hFF);
        cyc(3);
        check(matrix_runtime_irq, 1'b0);
        check(matrix_wake_irq, 1'b1);
        @(posedge pclk) scan_select_change <= 1'b1;
        @(posedge pclk) scan_select_change <= 1'b0;
        cyc(3);
        check(matrix_runtime_irq, 1'b1);
        @(posedge pclk) press <= 8'h00;
        cyc(4);
        apb(1'b1, 8'h0C, 32'hFF);
        rd_chk(8'h0C, 32'h0, 1'b0);
        cyc(2);
        check(matrix_wake_irq, 1'b0);
        @(posedge pclk) press <= 8'h10;
        apb(1'b1, 8'h0C, 32'hFF);
        rd_chk(8'h0C, 32'h10, 1'b0);
        check(matrix_runtime_irq, 1'b1);
        @(posedge pclk) press <= 8'h00;
        cyc(4);
        apb(1'b1, 8'h0C, 32'hFF);
        rd_chk(8'h0C, 32'h0, 1'b0);
        $display("edge test done");
    endtask
    task t_sleep;
        apb(1'b1, 8'h10, 32'h4);
        @(posedge pclk) bus_clk_stopped <= 1'b1;
        press <= 8'h03;
        cyc(6);
        check(matrix_wake_irq, 1'b0);
        @(posedge pclk) press <= 8'h07;
        cyc(6);
        check(clock_request, 1'b1);
        check(matrix_runtime_irq, 1'b0);
        rd_chk(8'h0C, 32'h07, 1'b0);
        @(posedge pclk) press <= 8'h00;
        apb(1'b1, 8'h0C, 32'hFF);
        cyc(2);
        check(matrix_wake_irq, 1'b1);
        @(posedge pclk) bus_clk_stopped <= 1'b0;
        cyc(3);
        check(clock_request, 1'b0);
        check(matrix_wake_irq, 1'b0);
        $display("sleep test done");
    endtask
    task t_pd;
        apb(1'b1, 8'h14, 32'h1);
        rd_chk(8'h14, 32'h1, 1'b0);
        @(posedge pclk) scan_level_req[0] <= 1'b1;
        cyc(1);
        check({scan_drive_lines_o[0], scan_drive_lines_oe[0]}, 2'b11);
        cyc(1);
        check({scan_drive_lines_o[0], scan_drive_lines_oe[0]}, 2'b11);
        cyc(1);
        check(scan_drive_lines_oe[0], 1'b0);
        @(posedge pclk) scan_level_req[0] <= 1'b0;
        cyc(2);
        check({scan_drive_lines_o[0], scan_drive_lines_oe[0]}, 2'b01);
        apb(1'b1, 8'h14, 32'h0);
        rd_chk(8'h14, 32'h0, 1'b0);
        @(posedge pclk) scan_level_req[0] <= 1'b1;
        cyc(1);
        check(scan_drive_lines_oe[0], 1'b0);
        @(posedge pclk) scan_level_req[0] <= 1'b0;
        $display("predrive test done");
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_edge();
        t_sleep();
        t_pd();
        test_done();
    end
endmodule
